/* File: logic/pcb_pkg.sv */
// Constants, enumerations and carrier structs of the pipelined bus block.
// Assumes one bus clock shared by every party on the bus.
`default_nettype none
package pcb_pkg;
    // ------------------------------------------------------------
    // Register map and status field positions
    // ------------------------------------------------------------
    localparam logic [3:0] REG_CFG = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h4;
    localparam logic [3:0] REG_IDLE = 4'h8;
    localparam int STAT_BUSY = 0;
    localparam int STAT_ILLEGAL = 1;
    localparam int STAT_STALL = 2;
    localparam int CFG_W = 10;
    // ------------------------------------------------------------
    // Pipeline depths and counts
    // ------------------------------------------------------------
    localparam logic [2:0] WR_DEPTH = 3'h1;
    localparam logic [2:0] MP_DEPTH = 3'h4;
    localparam logic [2:0] GAP_MAX = 3'h7;
    localparam logic [2:0] QUAD_BEATS_32 = 3'h4;
    localparam logic [2:0] QUAD_BEATS_64 = 3'h2;
    localparam logic [31:0] STEP_32 = 32'h0000_0004;
    localparam logic [31:0] STEP_64 = 32'h0000_0008;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {TGT_BANK0, TGT_BANK1, TGT_HOST, TGT_MPROC} tgt_t;
    typedef enum logic [1:0] {SZ_NORMAL, SZ_LONG, SZ_QUAD} size_t;
    typedef enum logic {PH_FIRST, PH_BURST} phase_t;
    typedef struct packed {
        logic wide;
        logic [2:0] idle;
        logic [2:0][1:0] depth;
    } cfg_t;
    // Bank 1 one cycle, host two cycles, all idle bits set, 32-bit bus
    localparam cfg_t CFG_RST = 10'h1d0;
    typedef struct packed {
        logic [31:0] addr;
        logic [63:0] data;
        tgt_t tgt;
        size_t size;
        logic write;
        logic [1:0] lanes;
    } cmd_t;
    typedef struct packed {
        logic valid;
        logic write;
        logic [63:0] data;
    } slot_t;
    localparam slot_t SLOT_NONE = '0;

    function automatic logic [2:0] beats(input size_t sz, input logic wide);
        logic [2:0] b;
        b = 3'h1;
        if (sz == SZ_LONG && !wide) begin
            b = 3'h2;
        end else if (sz == SZ_QUAD) begin
            b = wide ? QUAD_BEATS_64 : QUAD_BEATS_32;
        end
        return b;
    endfunction : beats
endpackage : pcb_pkg
`default_nettype wire

/* File: logic/pipelined_cluster_bus.sv */
// Pipelined cluster bus sequencer: master side issue and spacing, slave side
// burst grouping, and a small register port.
// Assumes all bus pins are synchronous to sys_clk and ack is resolved outside.
//
// Contract
// - Master may issue a new address cycle every bus cycle.
// - Data cycle follows address cycle by one to four cycles.
// - Read strobe for reads; low/high write strobes select valid 32-bit halves.
// - Burst continue active on every beat of a transaction but the last.
// - Writes always use a pipeline depth of one.
// - Reads from a peer processor always use depth four.
// - Read depth of bank 0, bank 1 and host is programmable.
// - Beat count follows size and bus width.
// - Slave groups burst-qualified beats; unqualified quad-only access is illegal.
// - Idle between reads to different slaves when second depth not larger.
// - Idle between reads from same bank when its idle bit is set.
// - Idle between read and write mix when second depth not larger.
// - Idle after a write to peer space before any further write.
// - After peer access, wait until it ends before memory or host access.
// - No idle inside bursts, between writes other than after a peer write, or same-slave reads without idle bit.
// - Smaller first depth lets address cycles go back to back.
// - Larger first depth delays second address by difference, plus idle.
// - First depth larger by one always inserts an idle cycle.
// - Depth codes zero to three mean one to four cycles.
// - Acknowledge low stalls every outstanding transaction.
`timescale 1ns/10ps
`default_nettype none
module pipelined_cluster_bus #(
    parameter logic [31:0] TCB_BASE = 32'h0000_0000,
    parameter logic [31:0] TCB_MASK = 32'hffff_ff00
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic req_valid,
    input wire pcb_pkg::cmd_t req_cmd,
    output logic req_ready,
    output logic rsp_valid,
    output logic [63:0] rsp_data,
    output logic [31:0] bus_addr,
    output logic read_strobe_n,
    output logic write_low_strobe_n,
    output logic write_high_strobe_n,
    output logic burst_continue_n,
    output logic [63:0] bus_data_out,
    output logic bus_data_oe,
    input wire logic [63:0] bus_data_in,
    input wire logic ack,
    input wire logic [31:0] bus_addr_in,
    input wire logic read_strobe_in_n,
    input wire logic write_low_strobe_in_n,
    input wire logic write_high_strobe_in_n,
    input wire logic burst_continue_in_n,
    output logic slv_valid,
    output logic [31:0] slv_addr,
    output logic slv_write,
    output logic [2:0] slv_beats,
    output logic slv_illegal
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        pcb_pkg::cmd_t [1:0] q;
        logic [1:0] qn;
        pcb_pkg::phase_t phase;
        logic [2:0] left;
        logic [2:0] since;
        logic have_last;
        logic last_write;
        pcb_pkg::tgt_t last_tgt;
        logic [2:0] last_depth;
        pcb_pkg::slot_t [3:0] pipe;
        pcb_pkg::slot_t dc;
        logic [31:0] addr;
        logic rd_n;
        logic wl_n;
        logic wh_n;
        logic bc_n;
        logic [63:0] dout;
        logic doe;
        logic rsp_valid;
        logic [63:0] rsp_data;
        logic req_ready;
        logic s_open;
        logic [31:0] s_addr;
        logic s_write;
        logic [2:0] s_beats;
        logic slv_valid;
        logic [31:0] slv_addr;
        logic slv_write;
        logic [2:0] slv_beats;
        logic slv_illegal;
        pcb_pkg::cfg_t cfg;
        logic illegal_st;
        logic [15:0] idles;
        logic [31:0] rdata;
    } st_t;

    st_t s_r;
    st_t s_nxt;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        pcb_pkg::cmd_t h;
        logic stall;
        logic issue;
        logic idle;
        logic drain;
        logic busy;
        logic pend;
        logic first;
        logic beat;
        logic [2:0] d;
        logic [2:0] bd;
        logic [2:0] gap;
        logic [2:0] nb;
        logic [2:0] left;
        logic [2:0] cnt;
        logic [1:0] sel;
        logic [1:0] qc;
        logic [31:0] a;
        s_nxt = s_r;
        h = s_r.q[0];
        stall = s_r.dc.valid && !ack;
        issue = 1'b0;
        idle = 1'b0;
        drain = 1'b0;
        pend = 1'b0;
        first = (s_r.phase == pcb_pkg::PH_FIRST);
        beat = 1'b0;
        d = pcb_pkg::WR_DEPTH;
        bd = 3'h1;
        gap = 3'h0;
        nb = pcb_pkg::beats(h.size, s_r.cfg.wide);
        left = 3'h0;
        cnt = 3'h0;
        sel = 2'h0;
        qc = s_r.qn;
        a = 32'h0000_0000;
        s_nxt.rsp_valid = 1'b0;
        s_nxt.slv_valid = 1'b0;
        s_nxt.slv_illegal = 1'b0;
        for (int i = 0; i < 4; i++) begin
            pend = pend | s_r.pipe[i].valid;
        end
        busy = s_r.dc.valid | pend;

        // --------------------------------------------------------
        // Depth and spacing of the head request
        // --------------------------------------------------------
        if (h.tgt != pcb_pkg::TGT_MPROC) begin
            sel = h.tgt;
        end
        if (!h.write) begin
            if (h.tgt == pcb_pkg::TGT_MPROC) begin
                d = pcb_pkg::MP_DEPTH;
            end else begin
                d = {1'b0, s_r.cfg.depth[sel]} + 3'h1;
            end
        end
        // Peers are not told apart, so two peer reads always get the idle
        if (!s_r.last_write && !h.write) begin
            if (s_r.last_tgt != h.tgt || h.tgt == pcb_pkg::TGT_MPROC) begin
                idle = (d <= s_r.last_depth);
            end else begin
                idle = s_r.cfg.idle[sel];
            end
        end else if (s_r.last_write != h.write) begin
            idle = (d <= s_r.last_depth);
        end else begin
            idle = (s_r.last_tgt == pcb_pkg::TGT_MPROC);
        end
        if (s_r.last_depth == d + 3'h1) begin
            idle = 1'b1;
        end
        if (s_r.last_depth > d) begin
            gap = s_r.last_depth - d;
        end
        gap = gap + {2'b00, idle};
        drain = (s_r.last_tgt == pcb_pkg::TGT_MPROC) && (h.tgt != pcb_pkg::TGT_MPROC) && pend;

        // --------------------------------------------------------
        // Master issue, frozen while a data cycle waits
        // --------------------------------------------------------
        if (!stall) begin
            s_nxt.dc = s_r.pipe[0];
            for (int i = 0; i < 3; i++) begin
                s_nxt.pipe[i] = s_r.pipe[i + 1];
            end
            s_nxt.pipe[3] = pcb_pkg::SLOT_NONE;
            s_nxt.dout = s_r.pipe[0].data;
            s_nxt.doe = s_r.pipe[0].valid && s_r.pipe[0].write;
            s_nxt.rd_n = 1'b1;
            s_nxt.wl_n = 1'b1;
            s_nxt.wh_n = 1'b1;
            s_nxt.bc_n = 1'b1;
            if (s_r.qn != 2'h0) begin
                if (!first) begin
                    issue = 1'b1;
                end else begin
                    issue = !s_r.have_last || (s_r.since >= gap && !drain);
                end
            end
            if (issue) begin
                left = first ? nb : s_r.left;
                bd = first ? d : s_r.last_depth;
                if (first) begin
                    s_nxt.addr = h.addr;
                    s_nxt.have_last = 1'b1;
                    s_nxt.last_write = h.write;
                    s_nxt.last_tgt = h.tgt;
                    s_nxt.last_depth = d;
                end else begin
                    s_nxt.addr = s_r.addr + (s_r.cfg.wide ? pcb_pkg::STEP_64 : pcb_pkg::STEP_32);
                end
                s_nxt.rd_n = h.write;
                s_nxt.wl_n = !(h.write && h.lanes[0]);
                s_nxt.wh_n = !(h.write && h.lanes[1]);
                s_nxt.bc_n = !(left > 3'h1);
                s_nxt.left = left - 3'h1;
                s_nxt.phase = (left > 3'h1) ? pcb_pkg::PH_BURST : pcb_pkg::PH_FIRST;
                s_nxt.pipe[bd - 3'h1] = '{valid: 1'b1, write: h.write, data: h.data};
                s_nxt.since = 3'h0;
            end else begin
                if (s_r.since != pcb_pkg::GAP_MAX) begin
                    s_nxt.since = s_r.since + 3'h1;
                end
                if (s_r.qn != 2'h0) begin
                    s_nxt.idles = s_r.idles + 16'h0001;
                end
            end
            if (s_r.dc.valid && !s_r.dc.write) begin
                s_nxt.rsp_valid = 1'b1;
                s_nxt.rsp_data = bus_data_in;
            end
        end

        // --------------------------------------------------------
        // Request queue, two deep so one beat per cycle keeps flowing
        // --------------------------------------------------------
        if (issue) begin
            s_nxt.q[0] = s_r.q[1];
            qc = s_r.qn - 2'h1;
        end
        if (req_valid && s_r.req_ready) begin
            s_nxt.q[qc[0]] = req_cmd;
            qc = qc + 2'h1;
        end
        s_nxt.qn = qc;
        s_nxt.req_ready = (qc != 2'h2);

        // --------------------------------------------------------
        // Slave side burst grouping
        // --------------------------------------------------------
        beat = !read_strobe_in_n || !write_low_strobe_in_n || !write_high_strobe_in_n;
        if (beat) begin
            cnt = s_r.s_open ? s_r.s_beats + 3'h1 : 3'h1;
            a = s_r.s_open ? s_r.s_addr : bus_addr_in;
            s_nxt.s_addr = a;
            s_nxt.s_beats = cnt;
            if (!s_r.s_open) begin
                s_nxt.s_write = read_strobe_in_n;
            end
            s_nxt.s_open = !burst_continue_in_n;
            if (burst_continue_in_n) begin
                s_nxt.slv_valid = 1'b1;
                s_nxt.slv_addr = a;
                s_nxt.slv_write = s_r.s_open ? s_r.s_write : read_strobe_in_n;
                s_nxt.slv_beats = cnt;
                // Quad-only window reached by anything but one whole quad
                s_nxt.slv_illegal = ((a & TCB_MASK) == TCB_BASE) &&
                    (cnt != (s_r.cfg.wide ? pcb_pkg::QUAD_BEATS_64 : pcb_pkg::QUAD_BEATS_32));
            end
        end

        // --------------------------------------------------------
        // Register port
        // --------------------------------------------------------
        if (reg_wr) begin
            if (reg_addr == pcb_pkg::REG_CFG) begin
                s_nxt.cfg = reg_wdata[pcb_pkg::CFG_W - 1:0];
            end
            if (reg_addr == pcb_pkg::REG_STAT && reg_wdata[pcb_pkg::STAT_ILLEGAL]) begin
                s_nxt.illegal_st = 1'b0;
            end
            if (reg_addr == pcb_pkg::REG_IDLE) begin
                s_nxt.idles = 16'h0000;
            end
        end
        // Set after clear so a same-cycle event survives
        if (s_nxt.slv_illegal) begin
            s_nxt.illegal_st = 1'b1;
        end
        s_nxt.rdata = 32'h0000_0000;
        if (reg_rd) begin
            unique case (reg_addr)
                pcb_pkg::REG_CFG: s_nxt.rdata = {22'h00_0000, s_r.cfg};
                pcb_pkg::REG_STAT: begin
                    s_nxt.rdata[pcb_pkg::STAT_BUSY] = busy || (s_r.qn != 2'h0);
                    s_nxt.rdata[pcb_pkg::STAT_ILLEGAL] = s_r.illegal_st;
                    s_nxt.rdata[pcb_pkg::STAT_STALL] = stall;
                end
                pcb_pkg::REG_IDLE: s_nxt.rdata = {16'h0000, s_r.idles};
                default: s_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_r <= '0;
            s_r.cfg <= pcb_pkg::CFG_RST;
            s_r.rd_n <= 1'b1;
            s_r.wl_n <= 1'b1;
            s_r.wh_n <= 1'b1;
            s_r.bc_n <= 1'b1;
            s_r.req_ready <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata = s_r.rdata;
    assign req_ready = s_r.req_ready;
    assign rsp_valid = s_r.rsp_valid;
    assign rsp_data = s_r.rsp_data;
    assign bus_addr = s_r.addr;
    assign read_strobe_n = s_r.rd_n;
    assign write_low_strobe_n = s_r.wl_n;
    assign write_high_strobe_n = s_r.wh_n;
    assign burst_continue_n = s_r.bc_n;
    assign bus_data_out = s_r.dout;
    assign bus_data_oe = s_r.doe;
    assign slv_valid = s_r.slv_valid;
    assign slv_addr = s_r.slv_addr;
    assign slv_write = s_r.slv_write;
    assign slv_beats = s_r.slv_beats;
    assign slv_illegal = s_r.slv_illegal;
endmodule : pipelined_cluster_bus
`default_nettype wire

/* File: verif/pcb_chk.sv */
// Concurrent checks on the master and slave side ports of the pipelined bus sequencer.
// Assumes a single bus clock and is bound into every sequencer instance.
`timescale 1ns/10ps
`default_nettype none
module pcb_chk (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic ack,
    input wire logic read_strobe_n,
    input wire logic write_low_strobe_n,
    input wire logic write_high_strobe_n,
    input wire logic burst_continue_n,
    input wire logic bus_data_oe,
    input wire logic [31:0] bus_addr,
    input wire logic rsp_valid,
    input wire logic slv_valid,
    input wire logic slv_illegal
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // ------
    // Bus sequencing
    // ------
    chk_strobe_excl: assert property (!read_strobe_n |-> write_low_strobe_n && write_high_strobe_n)
        else $error("read and write strobes together");
    chk_wr_depth: assert property (ack && !(write_low_strobe_n && write_high_strobe_n) |=> bus_data_oe)
        else $error("write data cycle missing one cycle after address");
    chk_oe_cause: assert property ($rose(bus_data_oe) |-> $past(!write_low_strobe_n || !write_high_strobe_n))
        else $error("data driven without a write address cycle");
    chk_rsp_acked: assert property (rsp_valid |-> $past(ack))
        else $error("read data returned without acknowledge");
    // Stretching the address keeps a slave that latched it in step
    chk_stall_hold: assert property (bus_data_oe && !ack |=> bus_data_oe && $stable(bus_addr) && $stable(read_strobe_n))
        else $error("bus moved during a stall");
    chk_idle_rd_wr: assert property (!read_strobe_n && ack |=> write_low_strobe_n && write_high_strobe_n)
        else $error("write issued right after a read");
    chk_burst_next: assert property (!burst_continue_n && ack |=> !(read_strobe_n && write_low_strobe_n && write_high_strobe_n))
        else $error("burst continuation without a following beat");
    chk_reset_quiet: assert property ($rose(resetn) |-> read_strobe_n && write_low_strobe_n && write_high_strobe_n && burst_continue_n && !bus_data_oe)
        else $error("bus not quiet out of reset");
    chk_illegal_pair: assert property (slv_illegal |-> slv_valid)
        else $error("illegal flag without a slave transaction");
endmodule : pcb_chk
bind pipelined_cluster_bus pcb_chk pcb_chk_inst (.sys_clk, .resetn, .ack, .read_strobe_n,
    .write_low_strobe_n, .write_high_strobe_n, .burst_continue_n, .bus_data_oe, .bus_addr,
    .rsp_valid, .slv_valid, .slv_illegal);
`default_nettype wire

/* File: verif/pcb_far_model.sv */
// Far side of the bus: memories, host and peers answering pipelined cycles.
// Assumes the target is coded in address bits 31:30 as the package's tgt_t.
`timescale 1ns/10ps
`default_nettype none
module pcb_far_model (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [9:0] cfg,
    input wire logic slow,
    input wire logic [31:0] bus_addr,
    input wire logic read_strobe_n,
    input wire logic write_low_strobe_n,
    input wire logic write_high_strobe_n,
    output logic [63:0] bus_data_in,
    output logic ack
);
    logic [4:1] pv_r, pw_r;
    logic [4:1][31:0] pa_r;
    logic [63:0] noise_r;
    logic [31:0] hit_addr;
    logic waited_r, hit, hit_wr;
    function automatic int depth_of(input logic [31:0] a, input logic wr);
        if (wr) return 1;
        if (a[31:30] == pcb_pkg::TGT_MPROC) return 4;
        return int'(cfg[{a[31:30], 1'b0} +: 2]) + 1;
    endfunction : depth_of
    always_comb begin
        hit = 1'b0;
        hit_wr = 1'b0;
        hit_addr = '0;
        for (int k = 1; k <= 4; k++) begin
            if (pv_r[k] && depth_of(pa_r[k], pw_r[k]) == k) begin
                hit = 1'b1;
                hit_wr = pw_r[k];
                hit_addr = pa_r[k];
            end
        end
        // Slow mode costs one wait cycle on every data cycle
        ack = !(slow && hit && !waited_r);
        // Off the data cycle the bus is not held, so it churns
        bus_data_in = (hit && !hit_wr) ? {~hit_addr, hit_addr} : noise_r;
    end
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pv_r <= '0;
            pw_r <= '0;
            pa_r <= '0;
            waited_r <= 1'b0;
            noise_r <= '0;
        end else begin
            noise_r <= noise_r + 64'h9e37_79b9_7f4a_7c15;
            waited_r <= !ack;
            if (ack) begin
                pv_r <= {pv_r[3:1], !(read_strobe_n && write_low_strobe_n && write_high_strobe_n)};
                pw_r <= {pw_r[3:1], read_strobe_n};
                pa_r <= {pa_r[3:1], bus_addr};
            end
        end
    end
endmodule : pcb_far_model
`default_nettype wire

/* File: verif/pipelined_cluster_bus_tb.sv */
// Self-checking bench for the pipelined bus sequencer, master and slave side.
// Assumes pcb_far_model answers on the bus and pcb_chk is bound in.
`timescale 1ns/10ps
`default_nettype none
module pipelined_cluster_bus_tb;
    typedef struct packed {logic [9:0] cfg; logic [1:0] ta, sa; logic wa, hb; logic [1:0] tb;
        logic wb, slow; logic [3:0] lat, nb, gap;} row_t;
    logic sys_clk, resetn, reg_wr, reg_rd, req_valid, req_ready, rsp_valid, ack, slow;
    logic read_strobe_n, write_low_strobe_n, write_high_strobe_n, burst_continue_n, bus_data_oe;
    logic read_strobe_in_n, write_low_strobe_in_n, burst_continue_in_n, wl_seen, wh_seen;
    logic slv_valid, slv_write, slv_illegal, write_high_strobe_in_n, bc_prev;
    logic [3:0] reg_addr;
    logic [2:0] slv_beats;
    logic [9:0] cfg_cur;
    logic [31:0] reg_wdata, reg_rdata, bus_addr, bus_addr_in, slv_addr, v, a_prev;
    logic [63:0] rsp_data, bus_data_out, bus_data_in, rsp_first;
    pcb_pkg::cmd_t req_cmd;
    int error_cnt, total_checks, cyc, bcnt;
    int addr_q[$], done_q[$];
    localparam row_t ROWS [20] = '{
        '{10'h1c0,0,0,0,0,0,0,0,2,1,0}, '{10'h1c1,0,0,0,0,0,0,0,3,1,0},
        '{10'h1c2,0,0,0,0,0,0,0,4,1,0}, '{10'h1c3,0,0,0,0,0,0,0,5,1,0},
        '{10'h1d0,2,0,0,0,0,0,0,3,1,0}, '{10'h1d0,3,0,0,0,0,0,0,5,1,0},
        '{10'h1d0,0,1,1,0,0,0,0,1,2,0}, '{10'h1d0,1,2,0,0,0,0,0,2,4,0},
        '{10'h3d0,1,2,0,0,0,0,0,2,2,0}, '{10'h3d0,1,1,0,0,0,0,0,2,1,0},
        '{10'h1d0,1,0,0,1,2,0,0,2,2,0}, '{10'h1d0,2,0,0,1,1,0,0,3,2,2},
        '{10'h000,0,0,0,1,0,0,0,2,2,0}, '{10'h1c0,0,0,0,1,0,0,0,2,2,1},
        '{10'h000,0,0,1,1,0,1,0,1,2,0}, '{10'h1d0,3,0,1,1,3,1,0,1,2,1},
        '{10'h1d0,1,0,0,1,0,1,0,2,2,1}, '{10'h1d0,3,0,0,1,1,0,0,5,2,4},
        '{10'h1d0,2,0,0,0,0,0,1,4,1,0}, '{10'h1d0,0,0,1,0,0,0,1,2,1,0}};
    pipelined_cluster_bus pipelined_cluster_bus_inst (.sys_clk, .resetn, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .req_valid, .req_cmd, .req_ready, .rsp_valid, .rsp_data,
        .bus_addr, .read_strobe_n, .write_low_strobe_n, .write_high_strobe_n, .burst_continue_n,
        .bus_data_out, .bus_data_oe, .bus_data_in, .ack, .bus_addr_in, .read_strobe_in_n,
        .write_low_strobe_in_n, .write_high_strobe_in_n, .burst_continue_in_n, .slv_valid,
        .slv_addr, .slv_write, .slv_beats, .slv_illegal);
    pcb_far_model pcb_far_model_inst (.sys_clk, .resetn, .cfg(cfg_cur), .slow, .bus_addr,
        .read_strobe_n, .write_low_strobe_n, .write_high_strobe_n, .bus_data_in, .ack);
    // ------
    // Clock, monitor and helpers
    // ------
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Only acknowledged cycles count, so a stretched address is seen once
    always @(posedge sys_clk) if (resetn) begin
        cyc++;
        if (ack && !(read_strobe_n && write_low_strobe_n && write_high_strobe_n)) begin
            addr_q.push_back(cyc);
            bcnt += int'(!burst_continue_n);
            wl_seen |= !write_low_strobe_n;
            wh_seen |= !write_high_strobe_n;
            if (bc_prev) chk("burst_addr", bus_addr, a_prev + (cfg_cur[9] ? 8 : 4));
            bc_prev = !burst_continue_n;
            a_prev = bus_addr;
        end
        if (bus_data_oe && ack) chk("wdata", bus_data_out, 64'h5a5a_0f0f);
        if (rsp_valid || (bus_data_oe && ack)) begin
            if (done_q.size() == 0) rsp_first = rsp_data;
            done_q.push_back(cyc);
        end
    end
    task automatic chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        d = reg_rdata;
    endtask : reg_read
    task automatic send(input pcb_pkg::cmd_t c, input int n);
        int t;
        for (int i = 0; i < n; i++) begin
            req_valid <= 1'b1;
            req_cmd <= c;
            t = 0;
            do begin @(posedge sys_clk); t++; end while (!req_ready && t < 50);
        end
    endtask : send
    task automatic run_row(input row_t r);
        pcb_pkg::cmd_t c;
        int na, t;
        na = r.nb - r.hb;
        reg_write(pcb_pkg::REG_CFG, {22'h0, r.cfg});
        cfg_cur <= r.cfg;
        slow <= r.slow;
        reg_read(pcb_pkg::REG_CFG, v);
        chk("cfg", v, {22'h0, r.cfg});
        addr_q.delete();
        done_q.delete();
        bcnt = 0;
        wl_seen = 1'b0;
        wh_seen = 1'b0;
        c = '0;
        c.addr = {r.ta, 30'h0000_0040};
        c.tgt = pcb_pkg::tgt_t'(r.ta);
        c.size = pcb_pkg::size_t'(r.sa);
        c.write = r.wa;
        c.lanes = 2'h1;
        c.data = 64'h5a5a_0f0f;
        send(c, na);
        if (r.hb) begin
            c.addr = {r.tb, 30'h0000_0080};
            c.tgt = pcb_pkg::tgt_t'(r.tb);
            c.size = pcb_pkg::SZ_NORMAL;
            c.write = r.wb;
            send(c, 1);
        end
        req_valid <= 1'b0;
        t = 0;
        while ((addr_q.size() < r.nb || done_q.size() < r.nb) && t < 60) begin
            @(posedge sys_clk);
            t++;
        end
        chk("beats", addr_q.size(), r.nb);
        chk("latency", done_q[0] - addr_q[0], r.lat);
        chk("burst", bcnt, na - 1);
        if (!r.wa) chk("rdata", rsp_first, {~{r.ta, 30'h0000_0040}, r.ta, 30'h0000_0040});
        else chk("lanes", {wh_seen, wl_seen}, 2'h1);
        if (r.hb) chk("gap", addr_q[na] - addr_q[na-1] - 1, r.gap);
    endtask : run_row
    task automatic slave_run(input int n, input logic [2:0] eb, input logic eill);
        int t;
        for (int i = 0; i < n; i++) begin
            bus_addr_in <= 32'h0000_0010 + 32'(4 * i);
            {write_high_strobe_in_n, write_low_strobe_in_n} <= {2{n == 1}};
            read_strobe_in_n <= (n != 1);
            burst_continue_in_n <= (i == n - 1);
            @(posedge sys_clk);
        end
        {write_high_strobe_in_n, write_low_strobe_in_n} <= 2'h3;
        read_strobe_in_n <= 1'b1;
        burst_continue_in_n <= 1'b1;
        bus_addr_in <= 32'hffff_ffe0;
        t = 0;
        do begin @(posedge sys_clk); t++; end while (!slv_valid && t < 8);
        chk("slv_beats", slv_beats, eb);
        chk("slv_illegal", slv_illegal, eill);
        chk("slv_addr", slv_addr, 32'h0000_0010);
        chk("slv_write", slv_write, n != 1);
    endtask : slave_run
    // ------
    // Main sequence
    // ------
    initial begin
        {resetn, reg_wr, reg_rd, req_valid, slow} = '0;
        {read_strobe_in_n, write_low_strobe_in_n, burst_continue_in_n, write_high_strobe_in_n} = 4'hf;
        reg_addr = '0;
        reg_wdata = '0;
        req_cmd = '0;
        bus_addr_in = '0;
        cfg_cur = pcb_pkg::CFG_RST;
        repeat (16) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        reg_read(pcb_pkg::REG_CFG, v);
        chk("cfg_reset", v, {22'h0, pcb_pkg::CFG_RST});
        reg_read(4'hc, v);
        chk("unmapped", v, 32'h0);
        foreach (ROWS[i]) run_row(ROWS[i]);
        slave_run(4, 3'h4, 1'b0);
        slave_run(1, 3'h1, 1'b1);
        reg_read(pcb_pkg::REG_STAT, v);
        chk("sticky", v[pcb_pkg::STAT_ILLEGAL], 1'b1);
        reg_write(pcb_pkg::REG_STAT, 32'h0000_0002);
        reg_read(pcb_pkg::REG_STAT, v);
        chk("cleared", v[pcb_pkg::STAT_ILLEGAL], 1'b0);
        give_verdict();
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        error_cnt++;
        give_verdict();
    end
endmodule : pipelined_cluster_bus_tb
`default_nettype wire
